// file: hdl/mps_pkg.sv
package mps_pkg;

	localparam int          ENTRIES     = 16;
	localparam int          PARAMS      = 8;
	localparam logic [6:0]  PARAM_BASE  = 7'h40;
	localparam logic [6:0]  LAST_WORD   = 7'h47;
	localparam logic [1:0]  F_SPEED     = 2'h0;
	localparam logic [1:0]  F_ACCEL     = 2'h1;
	localparam logic [1:0]  F_DECEL     = 2'h2;
	localparam logic [1:0]  F_TORQUE    = 2'h3;
	// Speeds in r/min, times in units of 0.1 s, torque in percent.
	localparam logic [12:0] SPD_MAX     = 13'h0FA0;
	localparam logic [12:0] SPD_MIN_DIG = 13'h0050;
	localparam logic [12:0] SPD_MIN_ANA = 13'h0064;
	localparam logic [12:0] SPD_INIT    = 13'h0000;
	localparam logic [12:0] REF_ANALOG  = 13'h0BB8;
	localparam logic [7:0]  TIME_MIN    = 8'h02;
	localparam logic [7:0]  TIME_MAX    = 8'h96;
	localparam logic [7:0]  TIME_INIT   = 8'h05;
	localparam logic [7:0]  TRQ_MAX     = 8'hC8;
	localparam logic [7:0]  TRQ_INIT    = 8'hC8;
	localparam logic [15:0] PARAM_INIT  = 16'h0000;
	// Two bits per parameter, parameter 0 lowest: 0,1 A; 2,3 B; 4,5 C; 6,7 D.
	localparam logic [15:0] PARAM_CLASS_MAP = 16'hFA50;

	typedef enum logic [1:0] {CLS_A, CLS_B, CLS_C, CLS_D} mps_class_e;
	typedef enum logic [1:0] {ST_LOAD, ST_LWAIT, ST_IDLE, ST_COMMIT} mps_state_e;

	typedef struct packed {
		logic [12:0] speed;
		logic [7:0]  accel;
		logic [7:0]  decel;
		logic [7:0]  torque;
	} mps_entry_s;

	typedef struct packed {
		logic        valid;
		logic [6:0]  addr;
		logic [15:0] data;
	} mps_wreq_s;

endpackage

// file: hdl/motor_parameter_store.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Power-up copies retained store into working RAM.
// RULE2 - Link writes change working RAM only.
// RULE3 - Commit command copies all RAM to retained store.
// RULE4 - Class A values apply on write.
// RULE5 - Class B values apply once motor stopped.
// RULE6 - Class C values apply on configuration command.
// RULE7 - Class D values apply only at power-up.
// RULE8 - Sixteen entries: speed, accel, decel, torque.
// RULE9 - Speed range depends on setting mode; init zero.
// RULE10 - Acceleration 0.2 to 15 s, init 0.5.
// RULE11 - Deceleration at least 0.2 s, init 0.5.
// RULE12 - Torque limit 0 to 200 percent, init 200.
// RULE13 - Analog mode accelerates against 3000 r/min reference.
// RULE14 - Analog mode decelerates from 3000 r/min reference.
// RULE15 - Analog mode speed from external input, else table.
// RULE16 - Master commits before power-off after class D changes.
// RULE17 - Master limits commits; store wears out.
// RULE18 - Four select pins index entries; 8-15 digital.
// RULE19 - Pending B, C, D values held apart from active.
module motor_parameter_store
	import mps_pkg::*;
(
	input  logic                   core_clk,
	input  logic                   resetn,
	input  mps_wreq_s              wrReq,
	input  logic                   commitCmd,
	input  logic                   configCmd,
	input  logic                   motorStopped,
	input  logic                   speedAnalogMode,
	input  logic                   entry_select_bit0,
	input  logic                   entry_select_bit1,
	input  logic                   entry_select_bit2,
	input  logic                   entry_select_bit3,
	input  logic [12:0]            analogSpeed,
	input  logic [6:0]             rdAddr,
	input  logic [15:0]            nvRdData,
	output logic [6:0]             nvAddr,
	output logic                   nvRdEn,
	output logic                   nvWrEn,
	output logic [15:0]            nvWrData,
	output logic                   busy,
	output logic                   loadDone,
	output logic                   wrRefused,
	output logic                   cmdRefused,
	output logic [15:0]            rdData,
	output logic [PARAMS-1:0][15:0] paramActive,
	output mps_entry_s             activeEntry,
	output logic [12:0]            speedCmd,
	output logic [12:0]            rampRefSpeed
);

	mps_state_e  state_q;
	mps_state_e  state_d;
	logic [6:0]  ptr_q;
	logic        lval_q;
	logic [6:0]  laddr_q;
	logic [4:0]  selMeta_q;
	logic [4:0]  selSync_q;
	mps_entry_s  ramTab_q [ENTRIES];
	logic [15:0] ramPar_q [PARAMS];

	function automatic logic inRange(input logic [6:0] a,
			input logic [15:0] d, input logic ana);
		logic [12:0] lo;
		lo = (ana && !a[5]) ? SPD_MIN_ANA : SPD_MIN_DIG;
		if (a > LAST_WORD)
			return 1'b0;
		if (a[6])
			return 1'b1;
		case (a[1:0])
			F_SPEED:  return d[15:13] == 3'h0 && d[12:0] >= lo
				&& d[12:0] <= SPD_MAX;
			F_TORQUE: return d[15:8] == 8'h00 && d[7:0] <= TRQ_MAX;
			default:  return d[15:8] == 8'h00 && d[7:0] >= TIME_MIN
				&& d[7:0] <= TIME_MAX;
		endcase
	endfunction

	function automatic logic [15:0] wordOf(input logic [6:0] a,
			input logic act);
		mps_entry_s e;
		e = ramTab_q[a[5:2]];
		if (a[6])
			return act ? paramActive[a[2:0]] : ramPar_q[a[2:0]];
		case (a[1:0])
			F_SPEED:  return {3'h0, e.speed};
			F_ACCEL:  return {8'h00, e.accel};
			F_DECEL:  return {8'h00, e.decel};
			default:  return {8'h00, e.torque};
		endcase
	endfunction

	wire [3:0]  entryIdx  = selSync_q[3:0];
	wire        useAnalog = selSync_q[4] && !entryIdx[3]; // RULE18
	wire        idle      = state_q == ST_IDLE;
	wire        reqOk     = wrReq.valid && idle
		&& inRange(wrReq.addr, wrReq.data, selSync_q[4]); // RULE9
	wire        wEn       = reqOk || lval_q;
	wire [6:0]  wAddr     = lval_q ? laddr_q : wrReq.addr;
	wire [15:0] wData     = lval_q ? nvRdData : wrReq.data;
	wire        lastPtr   = ptr_q == LAST_WORD;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_LOAD:   if (lastPtr) state_d = ST_LWAIT; // RULE1
			ST_LWAIT:  if (lval_q && !nvRdEn) state_d = ST_IDLE;
			ST_IDLE:   if (commitCmd) state_d = ST_COMMIT; // RULE3
			ST_COMMIT: if (lastPtr) state_d = ST_IDLE;
			default:   state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= ST_LOAD;
			ptr_q   <= 7'h00;
		end else begin
			state_q <= state_d;
			if (state_q == ST_IDLE || state_d == ST_IDLE)
				ptr_q <= 7'h00;
			else if (!lastPtr)
				ptr_q <= ptr_q + 7'h01;
		end
	end

	// The retained store is a synchronous memory with one cycle of read
	// latency, so each read is tracked until its word comes back.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			nvRdEn   <= 1'b0;
			nvWrEn   <= 1'b0;
			nvAddr   <= 7'h00;
			nvWrData <= 16'h0000;
			lval_q   <= 1'b0;
			laddr_q  <= 7'h00;
			busy     <= 1'b1;
			loadDone <= 1'b0;
		end else begin
			nvRdEn   <= state_q == ST_LOAD; // RULE1
			nvWrEn   <= state_q == ST_COMMIT; // RULE2 RULE3
			nvAddr   <= ptr_q;
			nvWrData <= wordOf(ptr_q, 1'b0); // RULE3
			lval_q   <= nvRdEn;
			laddr_q  <= nvAddr;
			busy     <= state_d != ST_IDLE;
			loadDone <= loadDone || (state_q == ST_LWAIT
				&& state_d == ST_IDLE);
		end
	end

	// Selection pins and mode come from outside the clock domain.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			selMeta_q <= 5'h00;
			selSync_q <= 5'h00;
		end else begin
			selMeta_q <= {speedAnalogMode, entry_select_bit3,
				entry_select_bit2, entry_select_bit1, entry_select_bit0};
			selSync_q <= selMeta_q;
		end
	end

	// The whole table applies at once, so one copy serves as both.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int e = 0; e < ENTRIES; e++) begin // RULE8
				ramTab_q[e] <= '{SPD_INIT, TIME_INIT, TIME_INIT,
					TRQ_INIT}; // RULE9 RULE10 RULE11 RULE12
			end
		end else if (wEn && !wAddr[6]) begin // RULE2 RULE10
			case (wAddr[1:0])
				F_SPEED:  ramTab_q[wAddr[5:2]].speed  <= wData[12:0];
				F_ACCEL:  ramTab_q[wAddr[5:2]].accel  <= wData[7:0];
				F_DECEL:  ramTab_q[wAddr[5:2]].decel  <= wData[7:0];
				default:  ramTab_q[wAddr[5:2]].torque <= wData[7:0];
			endcase
		end
	end

	logic [PARAMS-1:0] hit;
	logic [PARAMS-1:0] direct;
	logic [PARAMS-1:0] deferred;
	for (genvar i = 0; i < PARAMS; i++) begin : g_cls
		wire [1:0] cls = PARAM_CLASS_MAP[2*i +: 2];
		assign hit[i]      = wEn && wAddr == PARAM_BASE + 7'(i);
		assign direct[i]   = hit[i] && (lval_q || cls == CLS_A); // RULE4
		assign deferred[i] = (cls == CLS_B && motorStopped) // RULE5
			|| (cls == CLS_C && configCmd && idle); // RULE6
	end

	// Pending values wait in the working copy until their class allows.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int i = 0; i < PARAMS; i++) begin
				ramPar_q[i]    <= PARAM_INIT;
				paramActive[i] <= PARAM_INIT;
			end
		end else begin
			for (int i = 0; i < PARAMS; i++) begin
				if (hit[i])
					ramPar_q[i] <= wData; // RULE19
				if (direct[i])
					paramActive[i] <= wData; // RULE7
				else if (deferred[i])
					paramActive[i] <= ramPar_q[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			activeEntry  <= '{SPD_INIT, TIME_INIT, TIME_INIT, TRQ_INIT};
			speedCmd     <= SPD_INIT;
			rampRefSpeed <= SPD_INIT;
			rdData       <= 16'h0000;
			wrRefused    <= 1'b0;
			cmdRefused   <= 1'b0;
		end else begin
			activeEntry  <= ramTab_q[entryIdx];
			speedCmd     <= useAnalog ? analogSpeed
				: ramTab_q[entryIdx].speed; // RULE15
			rampRefSpeed <= useAnalog ? REF_ANALOG
				: ramTab_q[entryIdx].speed; // RULE13 RULE14
			rdData       <= wordOf(rdAddr, 1'b1);
			wrRefused    <= wrReq.valid && !reqOk;
			cmdRefused   <= (commitCmd || configCmd) && !idle;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	load_at_start_a: assert property ($past(!resetn) |-> busy // RULE1
		##1 nvRdEn[*8]) else $error("No load after reset.");
	nv_untouched_a: assert property (idle && !commitCmd |=> ##1 // RULE2
		!nvWrEn) else $error("Retained store written outside commit.");
	commit_walk_a: assert property (idle && commitCmd |=> // RULE3
		##1 nvWrEn[*8]) else $error("Commit did not write the store.");
	class_a_now_a: assert property (reqOk && wrReq.addr == PARAM_BASE // RULE4
		|=> paramActive[0] == $past(wrReq.data))
		else $error("Class A value not applied.");
	class_b_hold_a: assert property (idle && !motorStopped // RULE5
		|=> paramActive[2] == $past(paramActive[2]))
		else $error("Class B value applied while running.");
	class_c_cfg_a: assert property (idle && configCmd // RULE6
		|=> paramActive[4] == $past(ramPar_q[4]))
		else $error("Class C value not applied on configuration.");
	class_d_hold_a: assert property (idle |=> $stable(paramActive[6])) // RULE7
		else $error("Class D value changed after load.");
	speed_range_a: assert property (wrReq.valid && idle // RULE9
		&& wrReq.addr[6:0] == 7'h00 && wrReq.data > 16'h0FA0
		|=> wrRefused) else $error("Speed over range accepted.");
	torque_range_a: assert property (wrReq.valid && idle // RULE12
		&& !wrReq.addr[6] && wrReq.addr[1:0] == F_TORQUE
		&& wrReq.data > 16'h00C8
		|=> wrRefused) else $error("Torque over range accepted.");
	analog_ref_a: assert property (useAnalog // RULE13
		|=> rampRefSpeed == 13'h0BB8 && speedCmd == $past(analogSpeed))
		else $error("Analog reference wrong.");

	load_done_c: cover property (state_q == ST_LWAIT ##1 idle);
	commit_c: cover property (idle && commitCmd);
	defer_b_c: cover property (deferred[2] && ramPar_q[2] != paramActive[2]);

endmodule // motor_parameter_store

// file: sim/mps_nv_model.sv
`timescale 1ns/1ps
module mps_nv_model (
	input  logic        core_clk,
	input  logic [6:0]  nvAddr,
	input  logic        nvRdEn,
	input  logic        nvWrEn,
	input  logic [15:0] nvWrData,
	output logic [15:0] nvRdData
);
	logic [15:0] mem [0:71];
	initial begin
		for (int i = 0; i < 72; i++) begin
			mem[i] = 16'h0020 + 16'(i);
		end
		nvRdData = 16'h0000;
	end
	// Idle cycles return inverted data, so a stale read cannot match.
	always @(posedge core_clk) begin
		if (nvWrEn) begin
			mem[nvAddr] <= nvWrData;
		end
		nvRdData <= nvRdEn ? mem[nvAddr] : ~nvRdData;
	end
endmodule // mps_nv_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import mps_pkg::*;
	logic                    core_clk, resetn, commitCmd, configCmd;
	logic                    motorStopped, ana, busy, loadDone;
	logic                    wrRefused, cmdRefused, nvRdEn, nvWrEn;
	logic [3:0]              sel;
	logic [6:0]              rdAddr, nvAddr;
	logic [15:0]             nvRdData, nvWrData, rdData;
	logic [12:0]             speedCmd, rampRefSpeed;
	logic [PARAMS-1:0][15:0] paramActive;
	mps_entry_s              activeEntry;
	mps_wreq_s               wrReq;
	int                      fails, numChecks, cyc;
	// Refused flag, address, data.
	localparam logic [23:0] RT [9] = '{24'hA0004F, 24'h200050, 24'hA10001,
		24'hA10097, 24'h210096, 24'hA20001, 24'hA300C9, 24'h230000,
		24'h800FA1};
	motor_parameter_store dut (.core_clk(core_clk), .resetn(resetn),
		.wrReq(wrReq), .commitCmd(commitCmd), .configCmd(configCmd),
		.motorStopped(motorStopped), .speedAnalogMode(ana),
		.entry_select_bit0(sel[0]), .entry_select_bit1(sel[1]),
		.entry_select_bit2(sel[2]), .entry_select_bit3(sel[3]),
		.analogSpeed(13'h0555), .rdAddr(rdAddr), .nvRdData(nvRdData),
		.nvAddr(nvAddr), .nvRdEn(nvRdEn), .nvWrEn(nvWrEn),
		.nvWrData(nvWrData), .busy(busy), .loadDone(loadDone),
		.wrRefused(wrRefused), .cmdRefused(cmdRefused), .rdData(rdData),
		.paramActive(paramActive), .activeEntry(activeEntry),
		.speedCmd(speedCmd), .rampRefSpeed(rampRefSpeed));
	mps_nv_model nvm (.core_clk(core_clk), .nvAddr(nvAddr),
		.nvRdEn(nvRdEn), .nvWrEn(nvWrEn), .nvWrData(nvWrData),
		.nvRdData(nvRdData));
	task automatic end_of_test();
		if (fails == 0 && numChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		numChecks++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic idle_wait();
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge core_clk);
		#1;
		chk(16'(busy), 16'h0000);
	endtask
	task automatic power_up();
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		idle_wait();
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d,
		input logic r);
		@(posedge core_clk);
		wrReq <= '{valid: 1'b1, addr: a, data: d};
		@(posedge core_clk);
		wrReq.valid <= 1'b0;
		#1;
		chk(16'(wrRefused), 16'(r));
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge core_clk);
		rdAddr <= a;
		@(posedge core_clk);
		#1;
		chk(rdData, e);
	endtask
	task automatic pulse_cmd(input logic c);
		@(posedge core_clk);
		if (c) commitCmd <= 1'b1;
		else configCmd <= 1'b1;
		@(posedge core_clk);
		commitCmd <= 1'b0;
		configCmd <= 1'b0;
		#1;
	endtask
	task automatic t_load();
		chk(16'(loadDone), 16'h0001);
		for (int i = 0; i < 8; i++)
			chk(paramActive[i], 16'h0060 + 16'(i));
		rd(7'h05, 16'h0025);
	endtask
	task automatic t_classes();
		wr(7'h40, 16'h1234, 1'b0);
		chk(paramActive[0], 16'h1234);
		wr(7'h42, 16'h0ABC, 1'b0);
		chk(paramActive[2], 16'h0062);
		@(posedge core_clk);
		motorStopped <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk(paramActive[2], 16'h0ABC);
		wr(7'h44, 16'h0DEF, 1'b0);
		chk(paramActive[4], 16'h0064);
		pulse_cmd(1'b0);
		chk(paramActive[4], 16'h0DEF);
		wr(7'h46, 16'h0777, 1'b0);
		chk(paramActive[6], 16'h0066);
		chk(nvm.mem[70], 16'h0066);
	endtask
	task automatic t_commit();
		pulse_cmd(1'b1);
		chk(16'(busy), 16'h0001);
		pulse_cmd(1'b0);
		chk(16'(cmdRefused), 16'h0001);
		idle_wait();
		chk(nvm.mem[70], 16'h0777);
		power_up();
		chk(paramActive[6], 16'h0777);
		chk(paramActive[0], 16'h1234);
	endtask
	task automatic t_range();
		for (int i = 0; i < 9; i++)
			wr(RT[i][22:16], RT[i][15:0], RT[i][23]);
		rd(7'h20, 16'h0050);
		rd(7'h21, 16'h0096);
		rd(7'h22, 16'h0042);
	endtask
	task automatic t_select();
		@(posedge core_clk);
		sel <= 4'h8;
		ana <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk(16'(speedCmd), 16'h0050);
		chk(16'(rampRefSpeed), 16'h0050);
		chk(16'(activeEntry.torque), 16'h0000);
		@(posedge core_clk);
		sel <= 4'h0;
		repeat (4) @(posedge core_clk);
		#1;
		chk(16'(speedCmd), 16'h0555);
		chk(16'(rampRefSpeed), 16'h0BB8);
		// Analog mode raises the speed floor for the low entries.
		wr(7'h00, 16'h0050, 1'b1);
	endtask
	// A hang anywhere ends the run instead of stalling the regression.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		{resetn, commitCmd, configCmd, motorStopped, ana} = 5'h00;
		sel = 4'h0;
		rdAddr = 7'h00;
		wrReq = '0;
		power_up();
		t_load();
		t_classes();
		t_commit();
		t_range();
		t_select();
		end_of_test();
	end
endmodule // tb_top
